// *** common/bat_limiter_pkg.sv ***
// constants and register map of the battery tracking limiter control
// Contract
// - battery readout is 8-bit unsigned, full byte
// - readout at index 0x0c, resets to zero
// - ratio bits 7:6 select 1:1 to 4:1
// - ratio applies only below inflection threshold
// - inflection bits 5:3, 3.9 V down to 3.2 V
// - tracking below threshold lowers limiter threshold
// - bit 2 tracking: 0 fixed, 1 follows battery
// - mode 00 all off, 01 limiter always on
// - mode 10 mutes output below threshold
// - mode 11 limiter engages only below threshold
// - control at index 0x0d, resets to 0xa4
// - warning flag while level at/below threshold
// - flag while gain is being reduced
package bat_limiter_pkg;

   // register indices; byte address is four times the index
   localparam logic [7:0] READOUT_IDX   = 8'h0c;
   localparam logic [7:0] SETUP_IDX     = 8'h0d;
   localparam logic [7:0] STATUS_IDX    = 8'h10;
   localparam logic [7:0] READOUT_ADDR  = 8'h30;
   localparam logic [7:0] SETUP_ADDR    = 8'h34;
   localparam logic [7:0] STATUS_ADDR   = 8'h40;

   // reset values
   localparam logic [7:0] READOUT_RST   = 8'h00;
   localparam logic [7:0] SETUP_RST     = 8'ha4;

   // field positions in the limiter setup register
   localparam int RATIO_MSB    = 7;
   localparam int RATIO_LSB    = 6;
   localparam int INFL_MSB     = 5;
   localparam int INFL_LSB     = 3;
   localparam int TRACK_BIT    = 2;
   localparam int MODE_MSB     = 1;
   localparam int MODE_LSB     = 0;

   // field positions in the status register
   localparam int LOW_BAT_BIT  = 0;
   localparam int GAIN_RED_BIT = 5;
   localparam int RED_LSB      = 8;
   localparam int RED_MSB      = 15;

   // battery code scale: 3.9 V maps to 195, 0.1 V is 5 codes
   localparam logic [7:0] INFL_TOP_CODE  = 8'hc3;
   localparam logic [7:0] INFL_STEP_CODE = 8'h05;

   // limiter mode selection
   typedef enum logic [1:0] {
      MODE_OFF      = 2'b00,
      MODE_ON       = 2'b01,
      MODE_MUTE_LOW = 2'b10,
      MODE_ON_LOW   = 2'b11
   } limiter_mode_select_t;

   // axi response codes
   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage

// *** verif/bat_limiter_ctrl_checker.sv ***
// port-level assertions for the battery limiter control
`timescale 1ns/10ps
`default_nettype none
module bat_limiter_ctrl_checker (
   input wire logic        sys_clk_i,
   input wire logic        rst_n_i,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic        limiter_enable_o,
   input wire logic        mute_o,
   input wire logic [7:0]  threshold_reduction_o,
   input wire logic        low_battery_flag_o,
   input wire logic        gain_reduction_active_o
);
   // single domain, so one clock and one reset for every property
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!rst_n_i);

   // mute only below threshold, and strictly below implies the flag
   a_mute_warns: assert property (mute_o |-> low_battery_flag_o)
      else $error("mute without low battery flag");
   // mute mode neither engages the limiter nor counts as reduction
   a_mute_alone: assert property (
      mute_o |-> !limiter_enable_o && !gain_reduction_active_o)
      else $error("mute together with limiter activity");
   // reduction only while engaged and under the inflection point
   a_reduce_engaged: assert property (
      threshold_reduction_o != 8'h00 |->
         limiter_enable_o && low_battery_flag_o)
      else $error("reduction outside engaged low battery");
   a_reduce_flagged: assert property (
      threshold_reduction_o != 8'h00 |-> gain_reduction_active_o)
      else $error("reduction without gain reduction flag");
   // responses stand until the master takes them
   a_resp_holds: assert property (
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped early");
   a_data_holds: assert property (
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped early");
   a_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read address taken while data pending");
   // a taken answer never lingers, since no new address overlaps it
   a_read_done: assert property (
      s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("read data not released after handshake");
   a_write_done: assert property (
      s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write response not released after handshake");
   a_read_turn: assert property (
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   // both halves taken together: response exactly two edges later
   a_write_turn: assert property (s_axi_awvalid && s_axi_awready &&
      s_axi_wvalid && s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid)
      else $error("write answer at wrong edge");
endmodule
bind bat_limiter_ctrl bat_limiter_ctrl_checker i_bat_limiter_ctrl_checker (
   .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
   .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .limiter_enable_o(limiter_enable_o),
   .mute_o(mute_o), .threshold_reduction_o(threshold_reduction_o),
   .low_battery_flag_o(low_battery_flag_o),
   .gain_reduction_active_o(gain_reduction_active_o));
`default_nettype wire

// *** verif/tb_bat_limiter_ctrl.sv ***
// self-checking bench for the battery limiter control
`timescale 1ns/10ps
`default_nettype none
module tb_bat_limiter_ctrl;
   import bat_limiter_pkg::*;
   logic        clk = 1'h0, rst_n = 1'h0, awv = 1'h0, wv = 1'h0, bre = 1'h0;
   logic        arv = 1'h0, rre = 1'h0, bsv = 1'h0, act = 1'h0;
   logic [7:0]  awa = 8'h00, ara = 8'h00, bs = 8'h00, red;
   logic [31:0] wd = 32'h0, rdat;
   logic [3:0]  ws = 4'h0;
   logic [1:0]  br, rr;
   logic        awr, wrd, bv, arr, rv, le, mu, lf, gra;
   logic [11:0] e;
   int          err_total = 0, total_checks = 0, seed = 45, lvl = 0;
   int          s = 32'ha4;

   bat_limiter_ctrl i_bat_limiter_ctrl (
      .sys_clk_i(clk), .rst_n_i(rst_n), .s_axi_awaddr(awa),
      .s_axi_awprot(3'h0), .s_axi_awvalid(awv), .s_axi_awready(awr),
      .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
      .s_axi_wready(wrd), .s_axi_bresp(br), .s_axi_bvalid(bv),
      .s_axi_bready(bre), .s_axi_araddr(ara), .s_axi_arprot(3'h0),
      .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat),
      .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rre),
      .battery_sample_i(bs), .battery_sample_valid_i(bsv),
      .limiter_acting_i(act), .limiter_enable_o(le), .mute_o(mu),
      .threshold_reduction_o(red), .low_battery_flag_o(lf),
      .gain_reduction_active_o(gra));

   // 40 MHz system clock
   always #12.5 clk = ~clk;

   // reference: threshold code, strict below for actions, <= for the flag
   function automatic logic [11:0] model(input int l, c, input bit a);
      int t, q;
      bit b, en;
      t = INFL_TOP_CODE - INFL_STEP_CODE * ((c >> 3) & 7);
      b = l < t;
      en = (c & 3) == 1 || ((c & 3) == 3 && b);
      q = (c[2] && en && b) ? (t - l) * ((c >> 6) & 3) : 0;
      if (q > 255) q = 255;
      return {en, (c & 3) == 2 && b, l <= t,
              (en && a) || q != 0, q[7:0]};
   endfunction

   task automatic cmp(input logic [31:0] g, x);
      total_checks++;
      if (g !== x) begin
         err_total++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, g, x);
      end
   endtask

   // write: hold each half until its own ready, stall bready at random
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] st, input logic [1:0] x);
      bit pa, pw;
      pa = 1'b1;
      pw = 1'b1;
      @(posedge clk);
      awa <= a;
      wd <= d;
      ws <= st;
      awv <= 1'h1;
      wv <= 1'h1;
      // local pending flags: the driven valids are not yet updated here
      do begin
         @(posedge clk);
         if (pa && awr) begin
            awv <= 1'h0;
            pa = 1'b0;
         end
         if (pw && wrd) begin
            wv <= 1'h0;
            pw = 1'b0;
         end
      end while (pa || pw);
      repeat ($random(seed) & 1) @(posedge clk);
      bre <= 1'h1;
      do @(posedge clk); while (!bv);
      bre <= 1'h0;
      cmp({30'h0, br}, {30'h0, x});
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] x,
                     input logic [1:0] xr);
      @(posedge clk);
      ara <= a;
      arv <= 1'h1;
      do @(posedge clk); while (!arr);
      arv <= 1'h0;
      repeat ($random(seed) & 1) @(posedge clk);
      rre <= 1'h1;
      do @(posedge clk); while (!rv);
      rre <= 1'h0;
      cmp(rdat, x);
      cmp({30'h0, rr}, {30'h0, xr});
   endtask

   // one converter sample, then compare outputs once they have settled
   task automatic smp(input int v, input bit a);
      @(posedge clk);
      bs <= v[7:0];
      bsv <= 1'h1;
      act <= a;
      @(posedge clk);
      bsv <= 1'h0;
      lvl = v & 255;
      @(posedge clk);
      #1;
      e = model(lvl, s, a);
      cmp({20'h0, le, mu, lf, gra, red}, {20'h0, e});
   endtask

   task automatic conclude;
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // main sequence
   initial begin
      repeat (5) @(posedge clk);
      rst_n <= 1'h1;
      @(posedge clk);
      #1;
      cmp({20'h0, le, mu, lf, gra, red}, {20'h0, model(0, s, 0)});
      rd(READOUT_ADDR, 32'h0, RESP_OKAY);
      rd(SETUP_ADDR, 32'ha4, RESP_OKAY);
      rd(8'h38, 32'h0, RESP_SLVERR);
      wr(READOUT_ADDR, 32'h55, 4'hf, RESP_SLVERR);
      wr(SETUP_ADDR, 32'h03, 4'he, RESP_OKAY);
      rd(READOUT_ADDR, 32'h0, RESP_OKAY);
      rd(SETUP_ADDR, 32'ha4, RESP_OKAY);
      $display("test registers done");
      // every setup code, a level near the threshold then anywhere
      for (int i = 0; i < 256; i++) begin
         s = i;
         wr(SETUP_ADDR, s, 4'h1, RESP_OKAY);
         smp(193 - 5 * ((i >> 3) & 7) + ($random(seed) & 3),
             1'($random(seed)));
         smp($random(seed), 1'($random(seed)));
         rd(STATUS_ADDR, {16'h0, e[7:0], 2'h0, e[8], 4'h0, e[9]},
            RESP_OKAY);
         rd(READOUT_ADDR, lvl, RESP_OKAY);
      end
      $display("test setup sweep done");
      // second reset in mid-run restores both registers
      @(posedge clk);
      rst_n <= 1'h0;
      repeat (2) @(posedge clk);
      rst_n <= 1'h1;
      rd(READOUT_ADDR, 32'h0, RESP_OKAY);
      rd(SETUP_ADDR, 32'ha4, RESP_OKAY);
      // decisions fall back to readout zero against the reset setup
      s = 32'ha4;
      #1;
      cmp({20'h0, le, mu, lf, gra, red}, {20'h0, model(0, s, 0)});
      $display("test reset again done");
      conclude;
   end

   // watchdog: the sweep needs about 5000 cycles
   initial begin
      repeat (40000) @(posedge clk);
      err_total++;
      conclude;
   end
endmodule
`default_nettype wire

// *** verilog/bat_limiter_ctrl.sv ***
// battery tracking limiter control with axi4-lite register slave
`timescale 1ns/10ps
`default_nettype none
module bat_limiter_ctrl
   import bat_limiter_pkg::*;
(
   input  wire logic        sys_clk_i,
   input  wire logic        rst_n_i,
   // axi4-lite slave
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic [2:0]  s_axi_awprot,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic [2:0]  s_axi_arprot,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // battery measurement from the converter
   input  wire logic [7:0]  battery_sample_i,
   input  wire logic        battery_sample_valid_i,
   // limiter feedback and control
   input  wire logic        limiter_acting_i,
   output logic             limiter_enable_o,
   output logic             mute_o,
   output logic [7:0]       threshold_reduction_o,
   output logic             low_battery_flag_o,
   output logic             gain_reduction_active_o
);
   import bat_limiter_pkg::*;

   // stored registers
   logic [7:0]  battery_level_readout_r;
   logic [7:0]  limiter_setup_one_r;

   // write channel capture
   logic        aw_held_r;
   logic [7:0]  aw_addr_r;
   logic        w_held_r;
   logic [31:0] w_data_r;
   logic [3:0]  w_strb_r;
   logic        bvalid_r;
   logic [1:0]  bresp_r;

   // read channel
   logic        rvalid_r;
   logic [31:0] rdata_r;
   logic [1:0]  rresp_r;

   // decoded write
   logic        wr_fire;
   logic        wr_setup;
   logic        wr_ok;
   logic [7:0]  rd_byte_addr;

   // decoder outputs
   logic        flag_low;
   logic        flag_gain;
   logic [7:0]  reduction;
   logic [31:0] status_word;
   logic [31:0] rd_word;
   logic        rd_hit;

   // protection bits carry no meaning for this block
   logic        unused_prot;
   assign unused_prot = ^{s_axi_awprot, s_axi_arprot,
                          s_axi_wdata[31:8]};

   // ---- write address and data, taken in either order ----

   // ready only while the slot is empty, so a held beat is never lost
   assign s_axi_awready = !aw_held_r && !bvalid_r;
   assign s_axi_wready  = !w_held_r && !bvalid_r;

   // address slot
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         aw_held_r <= 1'b0;
         aw_addr_r <= 8'h00;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_held_r <= 1'b1;
         aw_addr_r <= s_axi_awaddr;
      end else if (wr_fire) begin
         aw_held_r <= 1'b0;
      end
   end

   // data slot
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         w_held_r <= 1'b0;
         w_data_r <= 32'h0000_0000;
         w_strb_r <= 4'h0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_held_r <= 1'b1;
         w_data_r <= s_axi_wdata;
         w_strb_r <= s_axi_wstrb;
      end else if (wr_fire) begin
         w_held_r <= 1'b0;
      end
   end

   // write executes once both halves are held
   assign wr_fire  = aw_held_r && w_held_r && !bvalid_r;
   assign wr_setup = wr_fire && (aw_addr_r == SETUP_ADDR);
   // readout and status are read only; writes there are refused
   assign wr_ok    = (aw_addr_r == SETUP_ADDR);

   // write response
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         bvalid_r <= 1'b0;
         bresp_r  <= RESP_OKAY;
      end else if (wr_fire) begin
         bvalid_r <= 1'b1;
         bresp_r  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         bvalid_r <= 1'b0;
      end
   end

   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp  = bresp_r;

   // ---- limiter setup register ----

   // only byte lane 0 carries the 8-bit register
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         limiter_setup_one_r <= SETUP_RST;
      end else if (wr_setup && w_strb_r[0]) begin
         limiter_setup_one_r <= w_data_r[7:0];
      end
   end

   // ---- battery readout ----

   // holds zero until the first measurement arrives
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         battery_level_readout_r <= READOUT_RST;
      end else if (battery_sample_valid_i) begin
         battery_level_readout_r <= battery_sample_i;
      end
   end

   // ---- decision logic ----

   // compares the stored readout, not the raw sample, so software
   // sees the value that steered the decision, except in the one cycle after the readout changes
   limiter_decide u_decide (
      .sys_clk_i               (sys_clk_i),
      .rst_n_i                 (rst_n_i),
      .level_i                 (battery_level_readout_r),
      .ratio_i                 (limiter_setup_one_r[RATIO_MSB:RATIO_LSB]),
      .inflection_i            (limiter_setup_one_r[INFL_MSB:INFL_LSB]),
      .track_i                 (limiter_setup_one_r[TRACK_BIT]),
      .mode_i                  (limiter_mode_select_t'(
                                limiter_setup_one_r[MODE_MSB:MODE_LSB])),
      .limiter_acting_i        (limiter_acting_i),
      .limiter_enable_o        (limiter_enable_o),
      .mute_o                  (mute_o),
      .low_battery_flag_o      (flag_low),
      .gain_reduction_active_o (flag_gain),
      .reduction_o             (reduction)
   );

   assign low_battery_flag_o      = flag_low;
   assign gain_reduction_active_o = flag_gain;
   assign threshold_reduction_o   = reduction;

   // ---- status word ----

   // live flags plus the present drop of the limiter threshold
   always_comb begin
      status_word = 32'h0000_0000;
      status_word[LOW_BAT_BIT]     = flag_low;
      status_word[GAIN_RED_BIT]    = flag_gain;
      status_word[RED_MSB:RED_LSB] = reduction;
   end

   // ---- read channel ----

   assign rd_byte_addr  = s_axi_araddr;
   assign s_axi_arready = !rvalid_r;

   // read decode; unmapped words read zero with an error
   always_comb begin
      rd_word = 32'h0000_0000;
      rd_hit  = 1'b1;
      unique case (rd_byte_addr)
         READOUT_ADDR: rd_word = {24'h00_0000, battery_level_readout_r};
         SETUP_ADDR:   rd_word = {24'h00_0000, limiter_setup_one_r};
         STATUS_ADDR:  rd_word = status_word;
         default:      rd_hit  = 1'b0;
      endcase
   end

   // read data registered one cycle after the address is taken
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         rvalid_r <= 1'b0;
         rdata_r  <= 32'h0000_0000;
         rresp_r  <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         rvalid_r <= 1'b1;
         rdata_r  <= rd_word;
         rresp_r  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
         rvalid_r <= 1'b0;
      end
   end

   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rdata  = rdata_r;
   assign s_axi_rresp  = rresp_r;

endmodule
`default_nettype wire

// *** verilog/limiter_decide.sv ***
// battery comparison and limiter decision, registered outputs
`timescale 1ns/10ps
`default_nettype none
module limiter_decide
   import bat_limiter_pkg::*;
(
   input  wire logic                 sys_clk_i,
   input  wire logic                 rst_n_i,
   input  wire logic [7:0]           level_i,
   input  wire logic [1:0]           ratio_i,
   input  wire logic [2:0]           inflection_i,
   input  wire logic                 track_i,
   input  wire limiter_mode_select_t mode_i,
   input  wire logic                 limiter_acting_i,
   output logic                      limiter_enable_o,
   output logic                      mute_o,
   output logic                      low_battery_flag_o,
   output logic                      gain_reduction_active_o,
   output logic [7:0]                reduction_o
);
   import bat_limiter_pkg::*;

   logic [7:0] thresh;
   logic       below;
   logic       at_or_below;
   logic [7:0] deficit;
   logic [9:0] scaled;
   logic       engaged;
   logic [7:0] red_nxt;

   // inflection code to battery code, 0.1 V per step
   always_comb begin
      thresh = 8'(INFL_TOP_CODE - 8'(inflection_i * INFL_STEP_CODE));
      below = level_i < thresh;
      at_or_below = level_i <= thresh;
      deficit = below ? 8'(thresh - level_i) : 8'h00;
   end

   // n:1 ratio drops the limit (n-1) codes per code of battery fall
   always_comb begin
      scaled = 10'(deficit) * 10'(ratio_i);
      engaged = 1'b0;
      unique case (mode_i)
         MODE_OFF:      engaged = 1'b0;
         MODE_ON:       engaged = 1'b1;
         MODE_MUTE_LOW: engaged = 1'b0;
         MODE_ON_LOW:   engaged = below;
      endcase
      // saturate so a deep sag never wraps to a small drop
      if (!(track_i && engaged && below))
         red_nxt = 8'h00;
      else if (scaled[9:8] != 2'b00)
         red_nxt = 8'hff;
      else
         red_nxt = scaled[7:0];
   end

   // all decisions land one cycle after the readout changes
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         limiter_enable_o        <= 1'b0;
         mute_o                  <= 1'b0;
         low_battery_flag_o      <= 1'b0;
         gain_reduction_active_o <= 1'b0;
         reduction_o             <= 8'h00;
      end else begin
         limiter_enable_o   <= engaged;
         mute_o             <= (mode_i == MODE_MUTE_LOW) && below;
         low_battery_flag_o <= at_or_below;
         gain_reduction_active_o <= (engaged && limiter_acting_i)
                                    || (red_nxt != 8'h00);
         reduction_o        <= red_nxt;
      end
   end

endmodule
`default_nettype wire
